// ==== hdl/dpl_pid_loop.sv ====
`timescale 1ns/10ps
`include "dpl_map.svh"
module dpl_pid_loop
   import dpl_pkg::*;
#(
   parameter int NUM_TERM = `DPL_NUM_TERM,
   parameter int CTRL_PERIOD_NS = `DPL_CTRL_PERIOD_NS
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NUM_TERM-1:0] term_in_i,
   input wire logic [11:0] ain1_i,
   input wire logic [11:0] ain2_i,
   input wire logic [11:0] ain4_i,
   input wire logic [15:0] freq_ref_i,
   output logic [15:0] freq_cmd_o,
   output logic pid_active_o,
   output logic upper_limit_o,
   output logic lower_limit_o,
   output logic irq_o
);
   localparam int PERIOD_CYC_RAW = CTRL_PERIOD_NS / `DPL_CLK_PERIOD_NS;
   localparam int PERIOD_CYC = (PERIOD_CYC_RAW < 1) ? 1 : PERIOD_CYC_RAW;
   localparam int CW = $clog2(PERIOD_CYC + 1);

   logic net_mode;
   logic [7:0] action_select_setting;
   logic [15:0] setpoint_parameter;
   logic [7:0] term1_function_setting;
   logic [7:0] term4_function_setting;
   logic [7:0] analog_range_select;
   logic [15:0] upper_limit_setting;
   logic [15:0] lower_limit_setting;
   logic [15:0] kp;
   logic [15:0] ki;
   logic [15:0] kd;
   logic [15:0] fmax;
   logic [7:0] input_terminal_function_codes [NUM_TERM];
   logic [`DPL_NUM_IRQ-1:0] irq_stat;
   logic [`DPL_NUM_IRQ-1:0] irq_en;
   logic [NUM_TERM-1:0] term_s1;
   logic [NUM_TERM-1:0] term_s2;
   logic [11:0] a1_s1, a1_s2, a2_s1, a2_s2, a4_s1, a4_s2;
   logic [CW-1:0] tick_cnt;
   logic tick;
   logic signed [39:0] integ;
   logic signed [13:0] err_prev;
   logic signed [13:0] err_now;
   logic upper_d, lower_d, run_d;

   logic [NUM_TERM-1:0] en_hits;
   logic [NUM_TERM-1:0] inv_hits;
   logic loop_enable_input;
   logic action_invert_input;
   dpl_mode_t mode;
   logic sel_fwd;
   logic dir_fwd;
   logic cfg_valid;
   logic run;
   logic lo5_t2;
   logic lo5_t1;
   logic signed [13:0] pct1;
   logic signed [13:0] pct2;
   logic signed [13:0] pct4;
   logic signed [13:0] setpoint;
   logic signed [39:0] next_integ;
   logic signed [39:0] sum;
   logic signed [39:0] ilim;
   logic [15:0] next_freq;
   logic wb_req;
   logic wb_wr;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [3:0] sel,
                                         input logic [31:0] dat);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return r;
   endfunction

   // unsigned code, 10V/20mA full scale; 5V range doubles gain
   function automatic logic signed [13:0] scale_u(input logic [11:0] c, input logic lo);
      logic [23:0] p;
      p = 24'(c) * 24'(`DPL_SCALE_MUL);
      p = p >> `DPL_SCALE_SHIFT;
      if (lo)
      begin
         p = p << 1;
      end
      if (p > 24'(`DPL_PCT_FULL))
      begin
         p = 24'(`DPL_PCT_FULL);
      end
      return 14'(p);
   endfunction

   // two's complement code, +-5V onto +-100%, +-10V onto +-50%
   function automatic logic signed [13:0] scale_s(input logic [11:0] c, input logic lo);
      logic signed [23:0] p;
      p = $signed({{12{c[11]}}, c}) * $signed({12'h000, `DPL_SCALE_MUL});
      p = p >>> `DPL_SCALE_SHIFT;
      if (lo)
      begin
         p = p <<< 1;
      end
      if (p > $signed(24'(`DPL_PCT_FULL)))
      begin
         p = $signed(24'(`DPL_PCT_FULL));
      end
      else if (p < -$signed(24'(`DPL_PCT_FULL)))
      begin
         p = -$signed(24'(`DPL_PCT_FULL));
      end
      return 14'(p);
   endfunction

   always_ff @(posedge clk_i)
   begin
      term_s1 <= term_in_i;
      term_s2 <= term_s1;
      a1_s1 <= ain1_i;
      a1_s2 <= a1_s1;
      a2_s1 <= ain2_i;
      a2_s2 <= a2_s1;
      a4_s1 <= ain4_i;
      a4_s2 <= a4_s1;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_TERM; gi++)
      begin : g_term
         assign en_hits[gi] = term_s2[gi] &&
            (input_terminal_function_codes[gi] == `DPL_FC_LOOP_EN); // RULE1
         assign inv_hits[gi] = term_s2[gi] &&
            (input_terminal_function_codes[gi] == `DPL_FC_INVERT); // RULE1
      end
   endgenerate

   assign loop_enable_input = |en_hits;
   assign action_invert_input = |inv_hits;

   always_comb
   begin
      unique case (action_select_setting)
         `DPL_AS_DEV_REV, `DPL_AS_DEV_FWD: mode = DPL_MODE_DEV; // RULE5
         `DPL_AS_MEAS_REV, `DPL_AS_MEAS_FWD: mode = DPL_MODE_MEAS; // RULE4
         default: mode = DPL_MODE_OFF;
      endcase
   end

   assign sel_fwd = (action_select_setting == `DPL_AS_DEV_FWD) ||
                    (action_select_setting == `DPL_AS_MEAS_FWD); // RULE13
   assign dir_fwd = sel_fwd ^ action_invert_input; // RULE13
   assign cfg_valid = (mode == DPL_MODE_DEV && term1_function_setting == 8'h00) || // RULE7
                      (mode == DPL_MODE_MEAS && term4_function_setting == 8'h00); // RULE8
   assign run = cfg_valid && (loop_enable_input || net_mode); // RULE1 RULE3

   // range codes that select the 5V span on terminal 2 and terminal 1
   always_comb
   begin
      unique case (analog_range_select)
         8'h01, 8'h03, 8'h05, 8'h0b, 8'h0d, 8'h0f: lo5_t2 = 1'b1; // RULE14
         default: lo5_t2 = 1'b0;
      endcase
      unique case (analog_range_select)
         8'h02, 8'h03, 8'h05, 8'h07, 8'h0c, 8'h0d, 8'h0f, 8'h11: lo5_t1 = 1'b1; // RULE15
         default: lo5_t1 = 1'b0;
      endcase
   end

   assign pct2 = scale_u(a2_s2, lo5_t2); // RULE14
   assign pct1 = scale_s(a1_s2, lo5_t1); // RULE15
   assign pct4 = scale_u(a4_s2, 1'b0);

   always_comb
   begin
      if (setpoint_parameter == `DPL_OFF_SETTING)
      begin
         setpoint = pct2 + pct1; // RULE6 RULE9
      end
      else
      begin
         setpoint = 14'(setpoint_parameter); // RULE6
      end
      if (mode == DPL_MODE_DEV)
      begin
         err_now = pct1; // RULE5
      end
      else
      begin
         err_now = setpoint - pct4; // RULE4
      end
   end

   // integral bound follows fmax so the accumulator cannot wind past the clamp
   always_comb
   begin
      ilim = 40'(fmax) <<< `DPL_GAIN_SHIFT;
      next_integ = integ + $signed({24'h000000, ki}) * 40'(err_now);
      if (next_integ > ilim)
      begin
         next_integ = ilim;
      end
      else if (next_integ < -ilim)
      begin
         next_integ = -ilim;
      end
      sum = $signed({24'h000000, kp}) * 40'(err_now) + next_integ +
            $signed({24'h000000, kd}) * 40'(err_now - err_prev); // RULE10 RULE18
      sum = sum >>> `DPL_GAIN_SHIFT;
      if (dir_fwd)
      begin
         sum = -sum; // RULE12
      end
      if (sum < 0)
      begin
         next_freq = 16'h0000; // RULE19
      end
      else if (sum > 40'(fmax))
      begin
         next_freq = fmax; // RULE19
      end
      else
      begin
         next_freq = 16'(sum); // RULE11
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || tick_cnt == CW'(PERIOD_CYC - 1))
      begin
         tick_cnt <= '0;
      end
      else
      begin
         tick_cnt <= tick_cnt + CW'(1);
      end
      tick <= !rst_i && tick_cnt == CW'(PERIOD_CYC - 1);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         integ <= '0;
         err_prev <= '0;
         freq_cmd_o <= 16'h0000;
         pid_active_o <= 1'b0;
      end
      else
      begin
         pid_active_o <= run;
         if (!run)
         begin
            integ <= '0;
            err_prev <= '0;
            freq_cmd_o <= freq_ref_i; // RULE2
         end
         else if (tick)
         begin
            integ <= next_integ; // RULE18
            err_prev <= err_now;
            freq_cmd_o <= next_freq; // RULE18
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         upper_limit_o <= 1'b0;
         lower_limit_o <= 1'b0;
      end
      else
      begin
         upper_limit_o <= mode == DPL_MODE_MEAS && upper_limit_setting != `DPL_OFF_SETTING &&
                          pct4 > $signed(14'(upper_limit_setting)); // RULE16
         lower_limit_o <= mode == DPL_MODE_MEAS && lower_limit_setting != `DPL_OFF_SETTING &&
                          pct4 < $signed(14'(lower_limit_setting)); // RULE17
      end
   end

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land on the edge at which the master sees ack, not one edge earlier
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         net_mode <= 1'b0;
         action_select_setting <= 8'h00;
         setpoint_parameter <= `DPL_RST_SETPOINT;
         term1_function_setting <= 8'h00;
         term4_function_setting <= 8'h00;
         analog_range_select <= 8'h01;
         upper_limit_setting <= `DPL_OFF_SETTING;
         lower_limit_setting <= `DPL_OFF_SETTING;
         kp <= 16'h0100;
         ki <= 16'h0000;
         kd <= 16'h0000;
         fmax <= `DPL_RST_FMAX;
         irq_en <= '0;
         for (int i = 0; i < NUM_TERM; i++)
         begin
            input_terminal_function_codes[i] <= 8'hff;
         end
      end
      else if (wb_wr)
      begin
         unique case (wb_adr_i)
            `DPL_ADR_CTRL: net_mode <= 1'(merge({31'h0, net_mode}, wb_sel_i, wb_dat_i));
            `DPL_ADR_ACTION:
               action_select_setting <= 8'(merge({24'h0, action_select_setting}, wb_sel_i,
                                                 wb_dat_i));
            `DPL_ADR_SETPOINT:
               setpoint_parameter <= 16'(merge({16'h0, setpoint_parameter}, wb_sel_i,
                                               wb_dat_i));
            `DPL_ADR_T1FUNC:
               term1_function_setting <= 8'(merge({24'h0, term1_function_setting}, wb_sel_i,
                                                  wb_dat_i));
            `DPL_ADR_T4FUNC:
               term4_function_setting <= 8'(merge({24'h0, term4_function_setting}, wb_sel_i,
                                                  wb_dat_i));
            `DPL_ADR_RANGE:
               analog_range_select <= 8'(merge({24'h0, analog_range_select}, wb_sel_i,
                                               wb_dat_i));
            `DPL_ADR_UPPER:
               upper_limit_setting <= 16'(merge({16'h0, upper_limit_setting}, wb_sel_i,
                                                wb_dat_i));
            `DPL_ADR_LOWER:
               lower_limit_setting <= 16'(merge({16'h0, lower_limit_setting}, wb_sel_i,
                                                wb_dat_i));
            `DPL_ADR_KP: kp <= 16'(merge({16'h0, kp}, wb_sel_i, wb_dat_i));
            `DPL_ADR_KI: ki <= 16'(merge({16'h0, ki}, wb_sel_i, wb_dat_i));
            `DPL_ADR_KD: kd <= 16'(merge({16'h0, kd}, wb_sel_i, wb_dat_i));
            `DPL_ADR_FMAX: fmax <= 16'(merge({16'h0, fmax}, wb_sel_i, wb_dat_i));
            `DPL_ADR_IRQ_EN:
               if (wb_sel_i[0])
                  irq_en <= wb_dat_i[`DPL_NUM_IRQ-1:0];
            default:
            begin
               for (int i = 0; i < NUM_TERM; i++)
               begin
                  if (wb_adr_i == `DPL_ADR_TFUNC + 8'(4 * i))
                  begin
                     input_terminal_function_codes[i] <=
                        8'(merge({24'h0, input_terminal_function_codes[i]}, wb_sel_i,
                                 wb_dat_i));
                  end
               end
            end
         endcase
      end
   end

   // a new event in the clearing cycle stays set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_stat <= '0;
         upper_d <= 1'b0;
         lower_d <= 1'b0;
         run_d <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         upper_d <= upper_limit_o;
         lower_d <= lower_limit_o;
         run_d <= pid_active_o;
         if (wb_wr && wb_adr_i == `DPL_ADR_IRQ_CLR && wb_sel_i[0])
         begin
            irq_stat <= (irq_stat & ~wb_dat_i[`DPL_NUM_IRQ-1:0]) |
                        {pid_active_o & ~run_d, lower_limit_o & ~lower_d, upper_limit_o & ~upper_d};
         end
         else
         begin
            irq_stat <= irq_stat |
                        {pid_active_o & ~run_d, lower_limit_o & ~lower_d, upper_limit_o & ~upper_d};
         end
         irq_o <= |(irq_stat & irq_en);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_req && !wb_we_i)
         begin
            unique case (wb_adr_i)
               `DPL_ADR_CTRL: wb_dat_o <= {31'h0, net_mode};
               `DPL_ADR_ACTION: wb_dat_o <= {24'h0, action_select_setting};
               `DPL_ADR_SETPOINT: wb_dat_o <= {16'h0, setpoint_parameter};
               `DPL_ADR_T1FUNC: wb_dat_o <= {24'h0, term1_function_setting};
               `DPL_ADR_T4FUNC: wb_dat_o <= {24'h0, term4_function_setting};
               `DPL_ADR_RANGE: wb_dat_o <= {24'h0, analog_range_select};
               `DPL_ADR_UPPER: wb_dat_o <= {16'h0, upper_limit_setting};
               `DPL_ADR_LOWER: wb_dat_o <= {16'h0, lower_limit_setting};
               `DPL_ADR_KP: wb_dat_o <= {16'h0, kp};
               `DPL_ADR_KI: wb_dat_o <= {16'h0, ki};
               `DPL_ADR_KD: wb_dat_o <= {16'h0, kd};
               `DPL_ADR_FMAX: wb_dat_o <= {16'h0, fmax};
               `DPL_ADR_ERROR: wb_dat_o <= 32'(err_now);
               `DPL_ADR_STATUS:
                  wb_dat_o <= {26'h0, action_invert_input, loop_enable_input, dir_fwd,
                               cfg_valid, mode};
               `DPL_ADR_FREQ: wb_dat_o <= {16'h0, freq_cmd_o};
               `DPL_ADR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
               `DPL_ADR_IRQ_EN: wb_dat_o <= {29'h0, irq_en};
               default:
               begin
                  for (int i = 0; i < NUM_TERM; i++)
                  begin
                     if (wb_adr_i == `DPL_ADR_TFUNC + 8'(4 * i))
                     begin
                        wb_dat_o <= {24'h0, input_terminal_function_codes[i]};
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule

// ==== shared/dpl_map.svh ====
// Function
// [RULE1] Run loop only while an input coded 14 is on; code 64 inverts action.
// [RULE2] Loop off: output follows the normal frequency command path.
// [RULE3] Network control mode runs the loop without the enable input.
// [RULE4] Select 20/21: measured value terminal 4, set point terminal 2 or parameter.
// [RULE5] Select 10/11: terminal 1 deviation is used directly as loop error.
// [RULE6] Set point parameter 0..100% used; value 9999 takes terminal 2 instead.
// [RULE7] Deviation mode invalid unless terminal 1 function setting is 0.
// [RULE8] Measured mode invalid unless terminal 4 function setting is 0.
// [RULE9] Measured mode adds terminal 1 to the terminal 2 set point.
// [RULE10] Loop output is the sum of P, I and D terms from deviation.
// [RULE11] Reverse action: positive deviation raises output, negative lowers it.
// [RULE12] Forward action: negative deviation raises output, positive lowers it.
// [RULE13] Select 10/20 reverse, 11/21 forward; invert input swaps direction.
// [RULE14] Terminal 2 scaled to 100% full scale over 5V, 10V or 20mA range.
// [RULE15] Terminal 1 scaled signed, minus to plus full scale onto -100..+100%; the 10V span reaches only -50..+50% here.
// [RULE16] Upper-limit output when measured value exceeds setting; 9999 disables.
// [RULE17] Lower-limit output when measured value below setting; 9999 disables.
// [RULE18] Deviation and terms are signed fixed-point percent, updated per period.
// [RULE19] Combined output clamped to permitted frequency range before use.
`ifndef DPL_MAP_SVH
`define DPL_MAP_SVH
`define DPL_ADR_CTRL 8'h00
`define DPL_ADR_ACTION 8'h04
`define DPL_ADR_SETPOINT 8'h08
`define DPL_ADR_T1FUNC 8'h0c
`define DPL_ADR_T4FUNC 8'h10
`define DPL_ADR_RANGE 8'h14
`define DPL_ADR_UPPER 8'h18
`define DPL_ADR_LOWER 8'h1c
`define DPL_ADR_KP 8'h20
`define DPL_ADR_KI 8'h24
`define DPL_ADR_KD 8'h28
`define DPL_ADR_FMAX 8'h2c
`define DPL_ADR_ERROR 8'h30
`define DPL_ADR_STATUS 8'h34
`define DPL_ADR_FREQ 8'h38
`define DPL_ADR_IRQ_STAT 8'h40
`define DPL_ADR_IRQ_CLR 8'h44
`define DPL_ADR_IRQ_EN 8'h48
`define DPL_ADR_TFUNC 8'h80
`define DPL_FC_LOOP_EN 8'h0e
`define DPL_FC_INVERT 8'h40
`define DPL_AS_DEV_REV 8'h0a
`define DPL_AS_DEV_FWD 8'h0b
`define DPL_AS_MEAS_REV 8'h14
`define DPL_AS_MEAS_FWD 8'h15
`define DPL_OFF_SETTING 16'h270f
`define DPL_PCT_FULL 16'h03e8
`define DPL_SCALE_MUL 12'hfa
`define DPL_SCALE_SHIFT 10
`define DPL_GAIN_SHIFT 8
`define DPL_RST_SETPOINT 16'h270f
`define DPL_RST_FMAX 16'h1770
`define DPL_CLK_PERIOD_NS 8
`define DPL_CTRL_PERIOD_NS 100000
`define DPL_NUM_TERM 12
`define DPL_IRQ_UPPER 0
`define DPL_IRQ_LOWER 1
`define DPL_IRQ_RUN 2
`define DPL_NUM_IRQ 3
`endif

// ==== shared/dpl_pkg.sv ====
package dpl_pkg;
   typedef enum logic [1:0]
   {
      DPL_MODE_OFF = 2'b00,
      DPL_MODE_DEV = 2'b01,
      DPL_MODE_MEAS = 2'b10
   } dpl_mode_t;
endpackage

// ==== verification/dpl_detector.sv ====
`timescale 1ns/10ps
// process detector: settles at once, or ramps in steps when slow_i is high
module dpl_detector
(
   input wire logic clk_i,
   input wire logic [11:0] target_i,
   input wire logic slow_i,
   output logic [11:0] ain4_o = 12'h000
);
   always @(posedge clk_i)
   begin
      if (!slow_i || ain4_o == target_i)
         ain4_o <= target_i;
      else if (ain4_o < target_i)
         ain4_o <= (target_i - ain4_o > 12'h040) ? ain4_o + 12'h040 : target_i;
      else
         ain4_o <= (ain4_o - target_i > 12'h040) ? ain4_o - 12'h040 : target_i;
   end
endmodule

// ==== verification/dpl_pid_checker.sv ====
`timescale 1ns/10ps
module dpl_pid_checker
#(
   parameter int NUM_TERM = 12,
   parameter int CTRL_PERIOD_NS = 100000
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NUM_TERM-1:0] term_in_i,
   input wire logic [11:0] ain1_i,
   input wire logic [11:0] ain2_i,
   input wire logic [11:0] ain4_i,
   input wire logic [15:0] freq_ref_i,
   input wire logic [15:0] freq_cmd_o,
   input wire logic pid_active_o,
   input wire logic upper_limit_o,
   input wire logic lower_limit_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack cycle");
   chk_off_follow: assert property (
      (!pid_active_o && !$past(pid_active_o) && !$past(rst_i))
      |-> freq_cmd_o == $past(freq_ref_i))
      else $error("loop off but command not following reference");
   // between control ticks the command must not move while the loop runs
   chk_tick_hold: assert property (
      (pid_active_o && $past(pid_active_o) && $changed(freq_cmd_o))
      |=> ($stable(freq_cmd_o) || !pid_active_o) [*8])
      else $error("command moved between control ticks");
   chk_freq_clamp: assert property (pid_active_o |-> freq_cmd_o <= 16'h1770)
      else $error("command above frequency limit");
   chk_irq_clear: assert property ((wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == 8'h44
      && $past(wb_dat_i[2:0]) == 3'h7) |-> ##[1:2] !irq_o)
      else $error("interrupt not cleared");
   cov_run: cover property ($rose(pid_active_o));
   cov_upper: cover property ($rose(upper_limit_o));
   cov_lower: cover property ($rose(lower_limit_o));
   cov_irq: cover property ($rose(irq_o));
endmodule
bind dpl_pid_loop dpl_pid_checker #(.NUM_TERM(NUM_TERM), .CTRL_PERIOD_NS(CTRL_PERIOD_NS)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .term_in_i(term_in_i), .ain1_i(ain1_i), .ain2_i(ain2_i),
   .ain4_i(ain4_i), .freq_ref_i(freq_ref_i), .freq_cmd_o(freq_cmd_o),
   .pid_active_o(pid_active_o), .upper_limit_o(upper_limit_o),
   .lower_limit_o(lower_limit_o), .irq_o(irq_o));

// ==== verification/drive_pid_loop_control_test.sv ====
`timescale 1ns/10ps
module drive_pid_loop_control_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic [11:0] term_in = 12'h000, ain1 = 12'h000, ain2 = 12'h000, target = 12'h000;
   logic [15:0] freq_ref = 16'h0000;
   logic [31:0] dat_o;
   logic [11:0] ain4;
   logic [15:0] freq_cmd;
   logic ack, act, upl, lol, irq;
   int mismatches = 0;
   int samples_checked = 0;

   initial forever #4 clk_i = ~clk_i;

   // a short control period keeps each tick ten clocks apart
   dpl_pid_loop #(.CTRL_PERIOD_NS(80)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .term_in_i(term_in), .ain1_i(ain1), .ain2_i(ain2),
      .ain4_i(ain4), .freq_ref_i(freq_ref), .freq_cmd_o(freq_cmd), .pid_active_o(act),
      .upper_limit_o(upl), .lower_limit_o(lol), .irq_o(irq));
   dpl_detector det (.clk_i(clk_i), .target_i(target), .slow_i(slow), .ain4_o(ain4));

   task close_out;
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1);
      q = dat_o;
      check(32'(n), 32'h2);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask

   // thirty clocks cover input synchronisers plus at least two control ticks
   task chk_out(input logic a, input logic [15:0] f);
      repeat (30) @(posedge clk_i);
      check(32'(act), 32'(a));
      check(32'(freq_cmd), 32'(f));
   endtask

   task t_reset;
      rd(8'h08, 32'h270f);
      rd(8'h2c, 32'h1770);
      rd(8'h14, 32'h1);
      rd(8'h80, 32'hff);
      wr(8'h3c, 32'h5);
      rd(8'h3c, 32'h0);
   endtask

   task t_rev_fwd;
      freq_ref <= 16'h1234;
      wr(8'h04, 32'h14);
      wr(8'h80, 32'he);
      wr(8'h08, 32'h1f4);
      chk_out(1'b0, 16'h1234);
      term_in <= 12'h001;
      chk_out(1'b1, 16'h1f4);
      rd(8'h30, 32'h1f4);
      wr(8'h08, 32'hc8);
      target <= 12'h800;
      chk_out(1'b1, 16'h0);
      wr(8'h04, 32'h15);
      chk_out(1'b1, 16'h12c);
      wr(8'h84, 32'h40);
      term_in <= 12'h003;
      chk_out(1'b1, 16'h0);
      rd(8'h34, 32'h36);
      term_in <= 12'h001;
      chk_out(1'b1, 16'h12c);
   endtask

   task t_term2;
      wr(8'h04, 32'h14);
      target <= 12'h000;
      ain2 <= 12'h400;
      wr(8'h08, 32'h270f);
      wr(8'h14, 32'h0);
      chk_out(1'b1, 16'hfa);
      wr(8'h14, 32'h1);
      chk_out(1'b1, 16'h1f4);
      wr(8'h14, 32'h6);
      chk_out(1'b1, 16'hfa);
      wr(8'h14, 32'h0);
      ain1 <= 12'h100;
      chk_out(1'b1, 16'h138);
      ain1 <= 12'h000;
   endtask

   task t_invalid_dev;
      wr(8'h10, 32'h1);
      chk_out(1'b0, 16'h1234);
      wr(8'h10, 32'h0);
      wr(8'h04, 32'ha);
      wr(8'h0c, 32'h1);
      chk_out(1'b0, 16'h1234);
      wr(8'h0c, 32'h0);
      ain1 <= 12'h100;
      chk_out(1'b1, 16'h3e);
      wr(8'h04, 32'hb);
      ain1 <= 12'hc00;
      chk_out(1'b1, 16'hfa);
      wr(8'h14, 32'h2);
      chk_out(1'b1, 16'h1f4);
      wr(8'h14, 32'h0);
      ain1 <= 12'h000;
   endtask

   task t_net;
      term_in <= 12'h000;
      wr(8'h04, 32'h14);
      wr(8'h08, 32'h1f4);
      chk_out(1'b0, 16'h1234);
      wr(8'h00, 32'h1);
      chk_out(1'b1, 16'h1f4);
      rd(8'h38, 32'h1f4);
      wr(8'h00, 32'h0);
      chk_out(1'b0, 16'h1234);
   endtask

   task t_limits;
      term_in <= 12'h001;
      slow <= 1'b1;
      wr(8'h48, 32'h1);
      wr(8'h18, 32'h64);
      wr(8'h44, 32'h7);
      target <= 12'h800;
      repeat (60) @(posedge clk_i);
      check(32'(upl), 32'h1);
      check(32'(irq), 32'h1);
      rd(8'h40, 32'h1);
      wr(8'h44, 32'h7);
      repeat (3) @(posedge clk_i);
      check(32'(irq), 32'h0);
      rd(8'h40, 32'h0);
      wr(8'h48, 32'h0);
      wr(8'h18, 32'h270f);
      repeat (5) @(posedge clk_i);
      check(32'(upl), 32'h0);
      wr(8'h1c, 32'h384);
      repeat (5) @(posedge clk_i);
      check(32'(lol), 32'h1);
      check(32'(irq), 32'h0);
      rd(8'h40, 32'h2);
      wr(8'h48, 32'h2);
      repeat (3) @(posedge clk_i);
      check(32'(irq), 32'h1);
      target <= 12'hfff;
      repeat (80) @(posedge clk_i);
      check(32'(lol), 32'h0);
   endtask

   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_rev_fwd;
      t_term2;
      t_invalid_dev;
      t_net;
      t_limits;
      close_out;
   end

   // the sequence needs about eight hundred and forty clocks
   initial
   begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      close_out;
   end
endmodule
